//--- hw/crs_cfg.svh
/*
 * Constants of the register file, stack pointer and interrupt control core.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ----------------------------------------------------------------------------
// Register file and data space
// ----------------------------------------------------------------------------
`define CRS_NUM_REGS 32
`define CRS_DS_REG_LIMIT 16'h0020
`define CRS_PTR_X_LOW 5'h1A
`define CRS_PTR_Y_LOW 5'h1C
`define CRS_PTR_Z_LOW 5'h1E

// ----------------------------------------------------------------------------
// I/O space locations and reset values
// ----------------------------------------------------------------------------
`define CRS_IO_SP_LOW 6'h3D
`define CRS_IO_SP_HIGH 6'h3E
`define CRS_IO_STATUS 6'h3F
`define CRS_SR_GIE_BIT 7
`define CRS_SP_RESET 16'h0000

// ----------------------------------------------------------------------------
// Sequencing
// ----------------------------------------------------------------------------
`define CRS_SEQ_CYCLES 4
`define CRS_PUSH_POP_STEPS 2
`define CRS_VEC_STRIDE 2

`endif

//--- hw/crs_pkg.sv
/*
 * Types shared by the register file, stack pointer and interrupt core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package crs_pkg;

   typedef enum logic [2:0]
   {
      crs_st_run = 3'b001,
      crs_st_entry = 3'b010,
      crs_st_return = 3'b100
   } crs_state_t;

   typedef enum logic [2:0]
   {
      crs_stk_none = 3'h0,
      crs_stk_push = 3'h1,
      crs_stk_pop = 3'h2,
      crs_stk_call = 3'h3,
      crs_stk_ret = 3'h4
   } crs_stk_op_t;

   typedef enum logic [1:0]
   {
      crs_ds_direct = 2'h0,
      crs_ds_x = 2'h1,
      crs_ds_y = 2'h2,
      crs_ds_z = 2'h3
   } crs_ds_sel_t;

endpackage

//--- hw/crs_regfile.sv
/*
 * Working register file: 32 bytes of flip-flops with two registered byte
 * read ports, one registered pair read, a data-space read and one write port
 * of 8 or 16 bits. Assumes one clock and an active-high asynchronous reset.
 */
`timescale 1ns/10ps
`include "crs_cfg.svh"

module crs_regfile
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic wr_wide_i,
   input wire logic [4:0] wr_addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic [4:0] rd_a_addr_i,
   input wire logic [4:0] rd_b_addr_i,
   input wire logic [4:0] ds_addr_i,
   output logic [7:0] rd_a_o,
   output logic [7:0] rd_b_o,
   output logic [15:0] rd_pair_o,
   output logic [7:0] ds_rdata_o,
   output logic [15:0] ptr_x_o,
   output logic [15:0] ptr_y_o,
   output logic [15:0] ptr_z_o
);

   logic [7:0] mem_q [`CRS_NUM_REGS];

   // A read that meets a write in the same cycle sees the new byte, so a
   // result written back is at once visible as the next operand.
   function automatic logic [7:0] fwd(input logic [4:0] a);
      logic [7:0] v;
      v = mem_q[a];
      if (wr_en_i && !wr_wide_i && wr_addr_i == a)
      begin
         v = wr_data_i[7:0];
      end
      else if (wr_en_i && wr_wide_i && wr_addr_i[4:1] == a[4:1])
      begin
         v = a[0] ? wr_data_i[15:8] : wr_data_i[7:0];
      end
      return v;
   endfunction

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < `CRS_NUM_REGS; i++)
         begin
            mem_q[i] <= 8'h00;
         end
      end
      else if (wr_en_i && wr_wide_i)
      begin
         mem_q[{wr_addr_i[4:1], 1'b0}] <= wr_data_i[7:0];
         mem_q[{wr_addr_i[4:1], 1'b1}] <= wr_data_i[15:8];
      end
      else if (wr_en_i)
      begin
         mem_q[wr_addr_i] <= wr_data_i[7:0];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_a_o <= 8'h00;
         rd_b_o <= 8'h00;
         rd_pair_o <= 16'h0000;
         ds_rdata_o <= 8'h00;
      end
      else
      begin
         rd_a_o <= fwd(rd_a_addr_i);
         rd_b_o <= fwd(rd_b_addr_i);
         rd_pair_o <= {fwd({rd_a_addr_i[4:1], 1'b1}), fwd({rd_a_addr_i[4:1], 1'b0})};
         ds_rdata_o <= fwd(ds_addr_i);
      end
   end

   assign ptr_x_o = {mem_q[`CRS_PTR_X_LOW + 5'h01], mem_q[`CRS_PTR_X_LOW]};
   assign ptr_y_o = {mem_q[`CRS_PTR_Y_LOW + 5'h01], mem_q[`CRS_PTR_Y_LOW]};
   assign ptr_z_o = {mem_q[`CRS_PTR_Z_LOW + 5'h01], mem_q[`CRS_PTR_Z_LOW]};

endmodule

//--- hw/crs_prio_enc.sv
/*
 * Fixed-priority encoder: the lowest requesting index wins.
 * Assumes IW is wide enough to hold N-1.
 */
`timescale 1ns/10ps

module crs_prio_enc
#(
   parameter int N = 20,
   parameter int IW = 5
)
(
   input wire logic [N-1:0] req_i,
   output logic valid_o,
   output logic [IW-1:0] idx_o
);

   always_comb
   begin
      valid_o = 1'b0;
      idx_o = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req_i[i])
         begin
            valid_o = 1'b1;
            idx_o = IW'(i);
         end
      end
   end

endmodule

//--- hw/crs_core.sv
/*
 * Register file, stack pointer and interrupt entry/return control of an
 * 8-bit core. Assumes decode presents operand addresses a cycle ahead of
 * execute, marks each completed instruction with insn_done_i, and that the
 * stack memory returns read data one cycle after stk_rd_o.
 */
// Functional notes
// - Four read/write port schemes, 8 and 16 bit.
// - Registers occupy first 32 data addresses.
// - Top six registers form X, Y, Z pointers.
// - Pointer accesses can reach any working register.
// - Stack grows downward; pointer marks its top.
// - Byte push lowers pointer one; pop raises.
// - Calls and entry lower by two; returns raise.
// - Pointer is two I/O bytes, reset zero.
// - Read two operands, compute, write back per cycle.
// - Fetch overlaps execute, one instruction per clock.
// - Take source only with own and global enable.
// - Vectors lowest; lower address higher priority.
// - Select bit and fuse move vectors to boot.
// - Boot lock bits may suppress interrupts by PC.
// - Entry clears global enable; return sets; nesting allowed.
// - Flags cleared on vectoring or writing one.
// - Disabled flags stay pending; served by priority.
// - Level sources request only while present.
// - One instruction runs after return before next interrupt.
// - Disable takes effect in its own cycle.
// - Entry takes four cycles, pushing the PC.
// - Return takes four cycles, pops, sets enable.
// - Instruction after enable runs before any interrupt.
`timescale 1ns/10ps
`include "crs_cfg.svh"

module crs_core
#(
   parameter int N_IRQ = 20,
   parameter int PCW = 14,
   parameter logic [N_IRQ-1:0] LEVEL_MASK = '0,
   parameter logic [PCW-1:0] BOOT_START = '0
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic insn_done_i,
   input wire logic [PCW-1:0] pc_i,
   input wire logic sei_i,
   input wire logic cli_i,
   input wire logic return_from_irq_op_i,
   input wire crs_pkg::crs_stk_op_t stk_op_i,
   input wire logic rf_wr_en_i,
   input wire logic rf_wr_wide_i,
   input wire logic [4:0] rf_wr_addr_i,
   input wire logic [15:0] rf_wr_data_i,
   input wire logic [4:0] rf_rd_a_addr_i,
   input wire logic [4:0] rf_rd_b_addr_i,
   output logic [7:0] rf_rd_a_o,
   output logic [7:0] rf_rd_b_o,
   output logic [15:0] rf_rd_pair_o,
   output logic [15:0] ptr_x_o,
   output logic [15:0] ptr_y_o,
   output logic [15:0] ptr_z_o,
   input wire crs_pkg::crs_ds_sel_t ds_sel_i,
   input wire logic [15:0] ds_addr_i,
   input wire logic ds_rd_i,
   input wire logic ds_wr_i,
   input wire logic [7:0] ds_wdata_i,
   output logic [7:0] ds_rdata_o,
   output logic ds_hit_o,
   input wire logic [5:0] io_addr_i,
   input wire logic io_rd_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   output logic [15:0] sp_o,
   input wire logic [N_IRQ-1:0] irq_flag_set_i,
   input wire logic [N_IRQ-1:0] irq_flag_clr_i,
   input wire logic [N_IRQ-1:0] irq_level_i,
   input wire logic [N_IRQ-1:0] irq_en_i,
   output logic [N_IRQ-1:0] irq_flag_o,
   input wire logic vector_base_select_i,
   input wire logic boot_reset_select_fuse_i,
   input wire logic boot_lock_app_bit_i,
   input wire logic boot_lock_boot_bit_i,
   output logic [PCW-1:0] reset_vector_o,
   output logic seq_busy_o,
   output logic gie_o,
   output logic pc_load_o,
   output logic [PCW-1:0] pc_load_val_o,
   output logic stk_wr_o,
   output logic stk_rd_o,
   output logic [15:0] stk_addr_o,
   output logic [7:0] stk_wdata_o,
   input wire logic [7:0] stk_rdata_i
);

   localparam int IW = $clog2(N_IRQ);
   localparam logic [1:0] SEQ_LAST = 2'(`CRS_SEQ_CYCLES - 1);
   localparam logic [1:0] STEPS = 2'(`CRS_PUSH_POP_STEPS);

   crs_pkg::crs_state_t state_q;
   logic [1:0] cnt_q;
   logic [15:0] sp_q;
   logic gie_q;
   logic hold_q;
   logic [N_IRQ-1:0] flag_q;
   logic [PCW-1:0] ret_pc_q;
   logic [PCW-1:0] vec_q;
   logic [IW-1:0] grant_q;
   logic [7:0] ret_high_q;
   logic [2:0] fuse_meta_q;
   logic [2:0] fuse_q;
   logic [N_IRQ-1:0] req;
   logic req_valid;
   logic [IW-1:0] req_idx;
   logic suppress;
   logic take;
   logic seq_done;
   logic [15:0] ds_eff;
   logic ds_is_reg;
   logic [15:0] ret_pc16;

   // ----------------------------------------------------------------------------
   // Register file and data-space window
   // ----------------------------------------------------------------------------
   always_comb
   begin
      unique case (ds_sel_i)
         crs_pkg::crs_ds_x: ds_eff = ptr_x_o;
         crs_pkg::crs_ds_y: ds_eff = ptr_y_o;
         crs_pkg::crs_ds_z: ds_eff = ptr_z_o;
         crs_pkg::crs_ds_direct: ds_eff = ds_addr_i;
      endcase
   end

   assign ds_is_reg = ds_eff < `CRS_DS_REG_LIMIT;

   // The execute write owns the port; decode never issues a data-space store
   // to a register in the same cycle as a result write.
   crs_regfile u_regfile
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_en_i(rf_wr_en_i || (ds_wr_i && ds_is_reg)),
      .wr_wide_i(rf_wr_en_i && rf_wr_wide_i),
      .wr_addr_i(rf_wr_en_i ? rf_wr_addr_i : ds_eff[4:0]),
      .wr_data_i(rf_wr_en_i ? rf_wr_data_i : {8'h00, ds_wdata_i}),
      .rd_a_addr_i(rf_rd_a_addr_i),
      .rd_b_addr_i(rf_rd_b_addr_i),
      .ds_addr_i(ds_eff[4:0]),
      .rd_a_o(rf_rd_a_o),
      .rd_b_o(rf_rd_b_o),
      .rd_pair_o(rf_rd_pair_o),
      .ds_rdata_o(ds_rdata_o),
      .ptr_x_o(ptr_x_o),
      .ptr_y_o(ptr_y_o),
      .ptr_z_o(ptr_z_o)
   );

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ds_hit_o <= 1'b0;
      end
      else
      begin
         ds_hit_o <= ds_rd_i && ds_is_reg;
      end
   end

   // ----------------------------------------------------------------------------
   // Fuse and lock straps
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fuse_meta_q <= 3'h0;
         fuse_q <= 3'h0;
         reset_vector_o <= '0;
      end
      else
      begin
         fuse_meta_q <= {boot_lock_boot_bit_i, boot_lock_app_bit_i, boot_reset_select_fuse_i};
         fuse_q <= fuse_meta_q;
         reset_vector_o <= fuse_q[0] ? BOOT_START : '0;
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt flags, requests and arbitration
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         flag_q <= '0;
      end
      else
      begin
         for (int i = 0; i < N_IRQ; i++)
         begin
            if (LEVEL_MASK[i])
            begin
               flag_q[i] <= 1'b0;
            end
            else if (irq_flag_set_i[i])
            begin
               flag_q[i] <= 1'b1;
            end
            else if (irq_flag_clr_i[i] || (take && req_idx == IW'(i)))
            begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   end

   assign irq_flag_o = flag_q;
   assign req = irq_en_i & ((LEVEL_MASK & irq_level_i) | (~LEVEL_MASK & flag_q));

   crs_prio_enc #(.N(N_IRQ), .IW(IW)) u_prio
   (
      .req_i(req),
      .valid_o(req_valid),
      .idx_o(req_idx)
   );

   // A lock that guards one section hides interrupts whose vectors sit in the
   // other section while code runs inside the guarded one.
   assign suppress = (fuse_q[1] && pc_i < BOOT_START && vector_base_select_i)
      || (fuse_q[2] && pc_i >= BOOT_START && !vector_base_select_i);

   assign take = state_q == crs_pkg::crs_st_run && insn_done_i && gie_q && !hold_q
      && !cli_i && !return_from_irq_op_i && !suppress && req_valid;
   assign seq_done = state_q != crs_pkg::crs_st_run && cnt_q == SEQ_LAST;

   // ----------------------------------------------------------------------------
   // Global enable and one-instruction hold
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gie_q <= 1'b0;
      end
      else if (take)
      begin
         gie_q <= 1'b0;
      end
      else if (seq_done && state_q == crs_pkg::crs_st_return)
      begin
         gie_q <= 1'b1;
      end
      else if (cli_i)
      begin
         gie_q <= 1'b0;
      end
      else if (sei_i)
      begin
         gie_q <= 1'b1;
      end
      else if (io_wr_i && io_addr_i == `CRS_IO_STATUS)
      begin
         gie_q <= io_wdata_i[`CRS_SR_GIE_BIT];
      end
   end

   assign gie_o = gie_q;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hold_q <= 1'b0;
      end
      else if (seq_done && state_q == crs_pkg::crs_st_return)
      begin
         hold_q <= 1'b1;
      end
      else if (state_q == crs_pkg::crs_st_run && insn_done_i)
      begin
         hold_q <= sei_i;
      end
   end

   // ----------------------------------------------------------------------------
   // Stack pointer
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sp_q <= `CRS_SP_RESET;
      end
      else if (state_q == crs_pkg::crs_st_entry && cnt_q < STEPS)
      begin
         sp_q <= sp_q - 16'h0001;
      end
      else if (state_q == crs_pkg::crs_st_return && cnt_q < STEPS)
      begin
         sp_q <= sp_q + 16'h0001;
      end
      else if (io_wr_i && io_addr_i == `CRS_IO_SP_LOW)
      begin
         sp_q <= {sp_q[15:8], io_wdata_i};
      end
      else if (io_wr_i && io_addr_i == `CRS_IO_SP_HIGH)
      begin
         sp_q <= {io_wdata_i, sp_q[7:0]};
      end
      else if (state_q == crs_pkg::crs_st_run)
      begin
         unique case (stk_op_i)
            crs_pkg::crs_stk_push: sp_q <= sp_q - 16'h0001;
            crs_pkg::crs_stk_pop: sp_q <= sp_q + 16'h0001;
            crs_pkg::crs_stk_call: sp_q <= sp_q - 16'h0002;
            crs_pkg::crs_stk_ret: sp_q <= sp_q + 16'h0002;
            crs_pkg::crs_stk_none: sp_q <= sp_q;
            default: sp_q <= sp_q;
         endcase
      end
   end

   assign sp_o = sp_q;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         io_rdata_o <= 8'h00;
      end
      else if (io_rd_i)
      begin
         unique case (io_addr_i)
            `CRS_IO_SP_LOW: io_rdata_o <= sp_q[7:0];
            `CRS_IO_SP_HIGH: io_rdata_o <= sp_q[15:8];
            `CRS_IO_STATUS: io_rdata_o <= {gie_q, 7'h00};
            default: io_rdata_o <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Entry and return sequencer
   // ----------------------------------------------------------------------------
   assign ret_pc16 = 16'(ret_pc_q);

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= crs_pkg::crs_st_run;
         cnt_q <= 2'h0;
         seq_busy_o <= 1'b0;
         ret_pc_q <= '0;
         vec_q <= '0;
         grant_q <= '0;
         ret_high_q <= 8'h00;
         pc_load_o <= 1'b0;
         pc_load_val_o <= '0;
         stk_wr_o <= 1'b0;
         stk_rd_o <= 1'b0;
         stk_addr_o <= 16'h0000;
         stk_wdata_o <= 8'h00;
      end
      else
      begin
         pc_load_o <= 1'b0;
         stk_wr_o <= 1'b0;
         stk_rd_o <= 1'b0;
         cnt_q <= (state_q == crs_pkg::crs_st_run) ? 2'h0 : cnt_q + 2'h1;
         unique case (state_q)
            crs_pkg::crs_st_run:
            begin
               if (take)
               begin
                  state_q <= crs_pkg::crs_st_entry;
                  seq_busy_o <= 1'b1;
                  ret_pc_q <= pc_i;
                  grant_q <= req_idx;
                  vec_q <= (vector_base_select_i ? BOOT_START : PCW'(0))
                     + PCW'((PCW'(req_idx) + PCW'(1)) * PCW'(`CRS_VEC_STRIDE));
               end
               else if (return_from_irq_op_i && insn_done_i)
               begin
                  state_q <= crs_pkg::crs_st_return;
                  seq_busy_o <= 1'b1;
               end
            end
            crs_pkg::crs_st_entry:
            begin
               stk_wr_o <= cnt_q < STEPS;
               stk_addr_o <= sp_q;
               stk_wdata_o <= (cnt_q == 2'h0) ? ret_pc16[7:0] : ret_pc16[15:8];
               if (seq_done)
               begin
                  state_q <= crs_pkg::crs_st_run;
                  seq_busy_o <= 1'b0;
                  pc_load_o <= 1'b1;
                  pc_load_val_o <= vec_q;
               end
            end
            crs_pkg::crs_st_return:
            begin
               stk_rd_o <= cnt_q < STEPS;
               stk_addr_o <= sp_q + 16'h0001;
               if (cnt_q == STEPS)
               begin
                  ret_high_q <= stk_rdata_i;
               end
               if (seq_done)
               begin
                  state_q <= crs_pkg::crs_st_run;
                  seq_busy_o <= 1'b0;
                  pc_load_o <= 1'b1;
                  pc_load_val_o <= PCW'({ret_high_q, stk_rdata_i});
               end
            end
            default:
            begin
               state_q <= crs_pkg::crs_st_run;
               seq_busy_o <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_cli_no_take: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cli_i |=> state_q != crs_pkg::crs_st_entry)
      else $error("interrupt taken in the disable cycle");
   a_entry_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == crs_pkg::crs_st_entry) |-> (state_q == crs_pkg::crs_st_entry)[*4] ##1 pc_load_o)
      else $error("entry not four cycles");
   a_entry_sp_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == crs_pkg::crs_st_entry) |-> ##2 sp_q == $past(sp_q, 2) - 16'h0002)
      else $error("entry did not lower stack pointer by two");
   a_entry_gie_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == crs_pkg::crs_st_entry) |-> !gie_q && $past(gie_q) && $past(|req))
      else $error("entry without enables or global enable left set");
   a_return_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == crs_pkg::crs_st_return) |-> (state_q == crs_pkg::crs_st_return)[*4] ##1 (gie_q && pc_load_o))
      else $error("return not four cycles or enable not set");
   a_return_sp_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == crs_pkg::crs_st_return) |-> ##2 sp_q == $past(sp_q, 2) + 16'h0002)
      else $error("return did not raise stack pointer by two");
   // Kept apart from the hold flop so that the check below does not lean on it.
   logic gap_seen_q;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gap_seen_q <= 1'b1;
      end
      else if ((seq_done && state_q == crs_pkg::crs_st_return) || (insn_done_i && sei_i))
      begin
         gap_seen_q <= 1'b0;
      end
      else if (insn_done_i && state_q == crs_pkg::crs_st_run)
      begin
         gap_seen_q <= 1'b1;
      end
   end

   a_hold_blocks: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == crs_pkg::crs_st_run && insn_done_i && !gap_seen_q) |=> state_q != crs_pkg::crs_st_entry)
      else $error("interrupt served without one instruction in between");
   a_push_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == crs_pkg::crs_st_run && stk_op_i == crs_pkg::crs_stk_push && !io_wr_i) |=> sp_q == $past(sp_q) - 16'h0001)
      else $error("push did not lower stack pointer by one");
   a_flag_pending: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!gie_q && !(|irq_flag_clr_i)) |=> (flag_q & $past(flag_q & ~LEVEL_MASK)) == $past(flag_q & ~LEVEL_MASK))
      else $error("pending flag lost while disabled");
   a_ds_reg_hit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (ds_rd_i && ds_eff < `CRS_DS_REG_LIMIT) |=> ds_hit_o)
      else $error("register file not reached through data space");

endmodule

//--- verif/cpu_regfile_stack_irq_core_bench.sv
/* Self-checking bench for crs_core: registers, stack pointer, interrupt entry and return.
   Assumes the hw/ files are compiled first and that the bench stands in for decode and stack memory. */
`timescale 1ns/10ps
module cpu_regfile_stack_irq_core_bench;
   logic ref_clk_i = 0, rst_i = 1, insn_done_i = 0, sei_i = 0, cli_i = 0, return_from_irq_op_i = 0, ds_hit_o, seq_busy_o;
   logic rf_wr_en_i = 0, rf_wr_wide_i = 0, ds_rd_i = 0, ds_wr_i = 0, io_rd_i = 0, io_wr_i = 0, gie_o;
   logic vector_base_select_i = 0, boot_reset_select_fuse_i = 0, boot_lock_app_bit_i = 0, boot_lock_boot_bit_i = 0;
   logic pc_load_o, stk_wr_o, stk_rd_o;
   logic [13:0] pc_i = 14'h0123, reset_vector_o, pc_load_val_o;
   logic [4:0] rf_wr_addr_i = 0, rf_rd_a_addr_i = 0, rf_rd_b_addr_i = 0;
   logic [15:0] rf_wr_data_i = 0, ds_addr_i = 0, rf_rd_pair_o, ptr_z_o, sp_o, stk_addr_o;
   logic [7:0] ds_wdata_i = 0, io_wdata_i = 0, stk_rdata_i = 0, rf_rd_a_o, rf_rd_b_o, ds_rdata_o, io_rdata_o, stk_wdata_o;
   logic [5:0] io_addr_i = 0;
   logic [19:0] irq_flag_set_i = 0, irq_flag_clr_i = 0, irq_level_i = 0, irq_en_i = 0, irq_flag_o;
   crs_pkg::crs_stk_op_t stk_op_i = crs_pkg::crs_stk_none;
   crs_pkg::crs_ds_sel_t ds_sel_i = crs_pkg::crs_ds_direct;
   int errors = 0, samples_checked = 0, k, n;
   crs_core #(.BOOT_START(14'h3800)) u_dut (.ref_clk_i, .rst_i, .insn_done_i, .pc_i, .sei_i, .cli_i, .return_from_irq_op_i,
      .stk_op_i, .rf_wr_en_i,
      .rf_wr_wide_i, .rf_wr_addr_i, .rf_wr_data_i, .rf_rd_a_addr_i, .rf_rd_b_addr_i, .rf_rd_a_o, .rf_rd_b_o,
      .rf_rd_pair_o, .ptr_x_o(), .ptr_y_o(), .ptr_z_o, .ds_sel_i, .ds_addr_i, .ds_rd_i, .ds_wr_i, .ds_wdata_i,
      .ds_rdata_o, .ds_hit_o, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o, .sp_o, .irq_flag_set_i,
      .irq_flag_clr_i, .irq_level_i, .irq_en_i, .irq_flag_o, .vector_base_select_i, .boot_reset_select_fuse_i,
      .boot_lock_app_bit_i, .boot_lock_boot_bit_i, .reset_vector_o, .seq_busy_o, .gie_o, .pc_load_o,
      .pc_load_val_o, .stk_wr_o, .stk_rd_o, .stk_addr_o, .stk_wdata_o, .stk_rdata_i);
   always #5 ref_clk_i = ~ref_clk_i;
   // The stack held 0x23 at the odd address and 0x01 below it; idle data toggles so it is never stale.
   always @(posedge ref_clk_i)
      stk_rdata_i <= stk_rd_o ? (stk_addr_o[0] ? 8'h23 : 8'h01) : ~stk_rdata_i;
   task chk(input string s, input logic [19:0] e, input logic [19:0] v);
      samples_checked++;
      if (v !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", s, e, v);
         errors++;
      end
   endtask
   task print_verdict;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task io(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= w;
      io_rd_i <= !w;
      @(posedge ref_clk_i);
      io_wr_i <= 0;
      io_rd_i <= 0;
      #1;
   endtask
   task rf_wr(input logic [4:0] a, input logic w, input logic [15:0] d);
      @(posedge ref_clk_i);
      rf_wr_addr_i <= a;
      rf_wr_wide_i <= w;
      rf_wr_data_i <= d;
      rf_wr_en_i <= 1;
      @(posedge ref_clk_i);
      rf_wr_en_i <= 0;
   endtask
   task stk(input crs_pkg::crs_stk_op_t op, input logic [15:0] e);
      @(posedge ref_clk_i);
      stk_op_i <= op;
      @(posedge ref_clk_i);
      stk_op_i <= crs_pkg::crs_stk_none;
      #1;
      chk("sp", e, sp_o);
   endtask
   task done(input logic s, input logic c, input logic r);
      @(posedge ref_clk_i);
      insn_done_i <= 1;
      sei_i <= s;
      cli_i <= c;
      return_from_irq_op_i <= r;
      @(posedge ref_clk_i);
      {insn_done_i, sei_i, cli_i, return_from_irq_op_i} <= 4'h0;
      #1;
   endtask
   task quiet;
      @(posedge ref_clk_i);
      #1;
      chk("busy", 0, seq_busy_o);
   endtask
   // Follows one entry or return from the take edge up to the program counter load.
   task seq(input logic [13:0] v);
      k = 0;
      for (n = 1; n < 9 && pc_load_o !== 1'b1; n++)
      begin
         @(posedge ref_clk_i);
         #1;
         if (stk_wr_o === 1'b1)
         begin
            chk("push addr", 16'h085F - k, stk_addr_o);
            chk("push data", k ? 8'h01 : 8'h23, stk_wdata_o);
            k++;
         end
      end
      chk("cycles", 5, n);
      chk("pc load", v, pc_load_val_o);
   endtask
   //----------------------------------------------------------------------
   // Test sequence
   //----------------------------------------------------------------------
   //----------------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 0;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("reset vector", 0, reset_vector_o);
      boot_reset_select_fuse_i <= 1;
      io(0, 6'h3E, 0);
      chk("sp high", 0, io_rdata_o);
      rf_wr(5'h05, 0, 16'h0012);
      rf_wr(5'h1E, 1, 16'h0005);
      rf_rd_a_addr_i <= 5'h1E;
      rf_rd_b_addr_i <= 5'h05;
      ds_addr_i <= 16'h0003;
      ds_wdata_i <= 8'h77;
      ds_wr_i <= 1;
      @(posedge ref_clk_i);
      {ds_wr_i, ds_rd_i} <= 2'b01;
      ds_sel_i <= crs_pkg::crs_ds_z;
      rf_rd_a_addr_i <= 5'h03;
      #1;
      chk("z ptr", 16'h0005, ptr_z_o);
      chk("pair", 16'h0005, rf_rd_pair_o);
      chk("rd b", 8'h12, rf_rd_b_o);
      @(posedge ref_clk_i);
      ds_rd_i <= 0;
      #1;
      chk("ds via z", 8'h12, ds_rdata_o);
      chk("ds hit", 1, ds_hit_o);
      chk("ds write", 8'h77, rf_rd_a_o);
      io(1, 6'h3D, 8'h5F);
      io(1, 6'h3E, 8'h08);
      io(0, 6'h3D, 0);
      chk("sp low", 8'h5F, io_rdata_o);
      stk(crs_pkg::crs_stk_push, 16'h085E);
      stk(crs_pkg::crs_stk_pop, 16'h085F);
      stk(crs_pkg::crs_stk_call, 16'h085D);
      stk(crs_pkg::crs_stk_ret, 16'h085F);
      irq_flag_set_i <= 20'h00006;
      irq_en_i <= 20'h00006;
      done(0, 0, 0);
      irq_flag_set_i <= 0;
      quiet();
      chk("flags", 20'h00006, irq_flag_o);
      done(1, 0, 0);
      done(0, 0, 0);
      quiet();
      done(0, 0, 0);
      seq(14'h0004);
      chk("gie entry", 0, gie_o);
      chk("flags", 20'h00004, irq_flag_o);
      chk("sp entry", 16'h085D, sp_o);
      io(0, 6'h3F, 0);
      chk("status", 0, io_rdata_o);
      done(0, 0, 1);
      seq(14'h0123);
      chk("gie return", 1, gie_o);
      chk("sp return", 16'h085F, sp_o);
      done(0, 0, 0);
      quiet();
      done(0, 1, 0);
      quiet();
      chk("gie cli", 0, gie_o);
      irq_flag_clr_i <= 20'h00004;
      @(posedge ref_clk_i);
      irq_flag_clr_i <= 0;
      #1;
      chk("flag clear", 0, irq_flag_o);
      chk("boot reset vector", 14'h3800, reset_vector_o);
      print_verdict();
   end
   initial
   begin
      #5000;
      errors++;
      print_verdict();
   end
endmodule
